/* File: logic/h2_frame_consts.vh */
`ifndef H2_FRAME_CONSTS_VH
`define H2_FRAME_CONSTS_VH

// Register byte addresses
`define ADDR_CTRL 8'h00
`define ADDR_PPM 8'h04
`define ADDR_HEALTH 8'h08
`define ADDR_RAW 8'h0C
`define ADDR_PART 8'h10
`define ADDR_FRAME_LO 8'h14
`define ADDR_FRAME_HI 8'h18
`define ADDR_INFO 8'h1C

// Control fields and reset values
`define CTRL_TX_EN_BIT 0
`define CTRL_PWM_BIT 1
`define CTRL_RST 2'h1
`define PPM_RST 16'h0000
`define HEALTH_RST 2'h0
`define RAW_RST 10'h000
`define PART_RST 5'h01
`define CNT_RST 8'h01

// Concentration code
`define CODE_OFFSET 17'h00014
`define CODE_MAX 17'h000F0
`define PPM_PER_STEP 17'h000C8
`define PPM_HALF_STEP 17'h00064

// Pulse widths in microseconds and the fatal health code
`define PWM_ERR_US 8'h0A
`define HEALTH_FATAL 2'h3

// Frame checksum
`define CRC_POLY 16'h1021
`define CRC_INIT 16'hFFFF

// Identifier base: sensor 1 is 0x640, step 8
`define CAN_ID_BASE 11'h638

// Timing
`define CLK_HZ 125000000
`define T_START_MS 700
`define T_REPEAT_MS 100
`define T_PWM_PERIOD_US 255

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: logic/h2_status_frame_and_pwm_encoder.v */
// Behaviour
// - Concentration code is 20 at zero, 240 at 4.4 percent, ppm/200 plus 20.
// - The ppm quotient is rounded to nearest, not truncated.
// - Check word starts as status in bits 9:8, code in bits 7:0.
// - Add the two lowest message counter bits to the check word.
// - Then invert the check word and add one.
// - Low 8 bits go out as first field, upper 2 as second.
// - Raw element signal: upper 8 bits in byte 2, lower 2 in byte 4 bits 7:6.
// - CRC16 high byte in byte 3, low byte in byte 7.
// - Sensor number 1 to 7 sits in byte 4 bits 4:2.
// - Message counter increments by one after each frame sent.
// - After 255 the counter value sent next is 0.
// - The first counter value used after start-up is 1.
// - Health status sits in byte 6 bits 2:1.
// - Release part number sits in byte 6 bits 7:3.
// - Pulse variant drives dominant or recessive only and is output only.
// - Pulse period is fixed at 255 microseconds.
// - Recessive time 20 to 240 microseconds, one microsecond per 200 ppm.
// - An internal error gives a 10 microsecond recessive time.
// - First frame 700 ms after reset, then one every 100 ms.
// - Eight byte frame in the documented byte order.
// - Sensor number comes from the supply feeds; identifier 0x640 plus 8 steps.
//
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "h2_frame_consts.vh"
`default_nettype none

module h2_status_frame_and_pwm_encoder #(
	parameter START_CYC = `T_START_MS * (`CLK_HZ / 1000),
	parameter REPEAT_CYC = `T_REPEAT_MS * (`CLK_HZ / 1000),
	parameter PWM_PERIOD_CYC = `T_PWM_PERIOD_US * (`CLK_HZ / 1000000)
) (
	input wire mclk,
	input wire nrst,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire id_feed_bit0,
	input wire id_feed_bit1,
	input wire id_feed_bit2,
	output reg [63:0] status_frame_ff,
	output reg frame_valid_ff,
	output reg [10:0] can_id_ff,
	output reg can_dominant_ff
);

	// Constants are cut to the counter widths on purpose
	localparam [31:0] CYC_PER_US_W = `CLK_HZ / 1000000;
	localparam [15:0] CYC_PER_US = CYC_PER_US_W[15:0];
	// A period above 65536 cycles would need a wider period counter
	localparam [31:0] PER_LAST_W = PWM_PERIOD_CYC - 1;
	localparam [15:0] PER_LAST = PER_LAST_W[15:0];
	localparam [31:0] START_LAST = START_CYC - 1;
	localparam [31:0] REPEAT_LAST = REPEAT_CYC - 1;

	reg [1:0] ctrl_ff;
	reg [15:0] ppm_ff;
	reg [1:0] health_ff;
	reg [9:0] raw_ff;
	reg [4:0] part_ff;
	reg [7:0] cnt_ff;
	reg started_ff;
	reg [31:0] tick_ff;
	reg [2:0] feed_s1_ff;
	reg [2:0] feed_s2_ff;
	reg [15:0] per_cnt_ff;
	reg [15:0] width_cyc_ff;
	reg aw_got_ff;
	reg w_got_ff;
	reg [7:0] waddr_ff;
	reg [31:0] wdata_ff;
	reg [3:0] wstrb_ff;

	wire tx_en = ctrl_ff[`CTRL_TX_EN_BIT];
	wire pwm_mode = ctrl_ff[`CTRL_PWM_BIT];
	wire [2:0] sensor_num = feed_s2_ff;

	function [15:0] crc_byte;
		input [15:0] c;
		input [7:0] d;
		integer i;
		reg [15:0] x;
		begin
			x = c ^ {d, 8'h00};
			for (i = 0; i < 8; i = i + 1)
				x = x[15] ? ({x[14:0], 1'b0} ^ `CRC_POLY) : {x[14:0], 1'b0};
			crc_byte = x;
		end
	endfunction

	wire [16:0] ppm_rnd = {1'b0, ppm_ff} + `PPM_HALF_STEP;
	wire [16:0] quot = ppm_rnd / `PPM_PER_STEP;
	wire [16:0] code_raw = quot + `CODE_OFFSET;
	// clamp, floor is 20 by construction
	wire [16:0] code_cl = (code_raw > `CODE_MAX) ? `CODE_MAX : code_raw;
	wire [7:0] conc_code = code_cl[7:0];

	wire [9:0] check_seed = {health_ff, conc_code};
	// add counter bits, wraps at 1024
	wire [9:0] check_sum = check_seed + {8'h00, cnt_ff[1:0]};
	wire [9:0] check_word = (~check_sum) + 10'h001;
	wire [7:0] check_low_byte = check_word[7:0];
	wire [1:0] check_high_pair = check_word[9:8];

	wire [7:0] raw_element_signal_upper = raw_ff[9:2];
	wire [1:0] raw_element_signal_lower = raw_ff[1:0];

	wire [7:0] byte4 = {raw_element_signal_lower, 1'b0, sensor_num, check_high_pair};
	wire [7:0] byte6 = {part_ff, health_ff, 1'b0};

	// checksum over bytes 0,1,2,4,5,6 in order
	wire [15:0] crc0 = crc_byte(`CRC_INIT, conc_code);
	wire [15:0] crc1 = crc_byte(crc0, check_low_byte);
	wire [15:0] crc2 = crc_byte(crc1, raw_element_signal_upper);
	wire [15:0] crc3 = crc_byte(crc2, byte4);
	wire [15:0] crc4 = crc_byte(crc3, cnt_ff);
	wire [15:0] crc5 = crc_byte(crc4, byte6);

	// byte 0 in bits 7:0, byte 7 in bits 63:56
	wire [63:0] nxt_frame = {crc5[7:0], byte6, cnt_ff, byte4,
		crc5[15:8], raw_element_signal_upper, check_low_byte, conc_code};

	wire tick_hit = (tick_ff == 32'h00000000);
	wire send = tick_hit && tx_en && !pwm_mode;

	// Feed pins are asynchronous straps
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			feed_s1_ff <= 3'h0;
			feed_s2_ff <= 3'h0;
		end
		else
		begin
			feed_s1_ff <= {id_feed_bit2, id_feed_bit1, id_feed_bit0};
			feed_s2_ff <= feed_s1_ff;
		end
	end

	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			can_id_ff <= 11'h000;
		else
			can_id_ff <= `CAN_ID_BASE + {5'h00, sensor_num, 3'h0};
	end

	// start delay, then fixed repeat; the timer runs even when idle
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			tick_ff <= START_LAST;
			started_ff <= 1'b0;
		end
		else if (tick_hit)
		begin
			tick_ff <= REPEAT_LAST;
			started_ff <= 1'b1;
		end
		else
			tick_ff <= tick_ff - 32'h00000001;
	end

	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			status_frame_ff <= 64'h0000000000000000;
			frame_valid_ff <= 1'b0;
			cnt_ff <= `CNT_RST;
		end
		else
		begin
			frame_valid_ff <= send;
			// Skipped frames leave the counter where it is
			if (send)
			begin
				status_frame_ff <= nxt_frame;
				// 8-bit wrap gives 0 after 255
				cnt_ff <= cnt_ff + 8'h01;
			end
		end
	end

	// width in microseconds equals the code, or PWM_ERR_US when health is HEALTH_FATAL
	wire [7:0] width_us = (health_ff == `HEALTH_FATAL) ? `PWM_ERR_US : conc_code;
	wire [15:0] nxt_width_cyc = {8'h00, width_us} * CYC_PER_US;
	// A width beyond the period leaves the output recessive all period
	wire period_end = (per_cnt_ff == PER_LAST);

	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			per_cnt_ff <= 16'h0000;
			width_cyc_ff <= 16'h0000;
			can_dominant_ff <= 1'b0;
		end
		else
		begin
			per_cnt_ff <= period_end ? 16'h0000 : per_cnt_ff + 16'h0001;
			// width latched only at the boundary
			if (period_end)
				width_cyc_ff <= nxt_width_cyc;
			// recessive first, dominant for the rest; idle recessive
			can_dominant_ff <= pwm_mode && (per_cnt_ff >= width_cyc_ff);
		end
	end

	// AXI4-Lite write path: address and data taken in either order
	wire wr_go = aw_got_ff && w_got_ff && !s_axi_bvalid;
	wire [31:0] wmask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}},
		{8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
	wire wr_hit = (waddr_ff == `ADDR_CTRL) || (waddr_ff == `ADDR_PPM) ||
		(waddr_ff == `ADDR_HEALTH) || (waddr_ff == `ADDR_RAW) ||
		(waddr_ff == `ADDR_PART);

	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
			aw_got_ff <= 1'b0;
			w_got_ff <= 1'b0;
			waddr_ff <= 8'h00;
			wdata_ff <= 32'h00000000;
			wstrb_ff <= 4'h0;
		end
		else
		begin
			if (s_axi_awready && s_axi_awvalid)
			begin
				s_axi_awready <= 1'b0;
				aw_got_ff <= 1'b1;
				// Every register is one aligned word, low address bits ignored
				waddr_ff <= {s_axi_awaddr[7:2], 2'h0};
			end
			else if (!aw_got_ff && !s_axi_bvalid)
				s_axi_awready <= 1'b1;
			if (s_axi_wready && s_axi_wvalid)
			begin
				s_axi_wready <= 1'b0;
				w_got_ff <= 1'b1;
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end
			else if (!w_got_ff && !s_axi_bvalid)
				s_axi_wready <= 1'b1;
			if (wr_go)
			begin
				aw_got_ff <= 1'b0;
				w_got_ff <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	wire [31:0] ctrl_new = ({30'h0, ctrl_ff} & ~wmask) | (wdata_ff & wmask);
	wire [31:0] ppm_new = ({16'h0, ppm_ff} & ~wmask) | (wdata_ff & wmask);
	wire [31:0] health_new = ({30'h0, health_ff} & ~wmask) | (wdata_ff & wmask);
	wire [31:0] raw_new = ({22'h0, raw_ff} & ~wmask) | (wdata_ff & wmask);
	wire [31:0] part_new = ({27'h0, part_ff} & ~wmask) | (wdata_ff & wmask);

	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			ctrl_ff <= `CTRL_RST;
			ppm_ff <= `PPM_RST;
			health_ff <= `HEALTH_RST;
			raw_ff <= `RAW_RST;
			part_ff <= `PART_RST;
		end
		else if (wr_go)
		begin
			case (waddr_ff)
				`ADDR_CTRL: ctrl_ff <= ctrl_new[1:0];
				`ADDR_PPM: ppm_ff <= ppm_new[15:0];
				`ADDR_HEALTH: health_ff <= health_new[1:0];
				`ADDR_RAW: raw_ff <= raw_new[9:0];
				`ADDR_PART: part_ff <= part_new[4:0];
				default: ctrl_ff <= ctrl_ff;
			endcase
		end
	end

	// AXI4-Lite read path: one read in flight, data registered at acceptance
	reg [31:0] rd_mux;
	reg rd_hit;

	always @*
	begin
		rd_hit = 1'b1;
		case ({s_axi_araddr[7:2], 2'h0})
			`ADDR_CTRL: rd_mux = {30'h0, ctrl_ff};
			`ADDR_PPM: rd_mux = {16'h0, ppm_ff};
			`ADDR_HEALTH: rd_mux = {30'h0, health_ff};
			`ADDR_RAW: rd_mux = {22'h0, raw_ff};
			`ADDR_PART: rd_mux = {27'h0, part_ff};
			`ADDR_FRAME_LO: rd_mux = status_frame_ff[31:0];
			`ADDR_FRAME_HI: rd_mux = status_frame_ff[63:32];
			`ADDR_INFO: rd_mux = {started_ff, 4'h0, can_id_ff, 5'h00, sensor_num, cnt_ff};
			default:
			begin
				rd_mux = 32'h00000000;
				rd_hit = 1'b0;
			end
		endcase
	end

	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RESP_OKAY;
		end
		else
		begin
			if (s_axi_arready && s_axi_arvalid)
			begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_mux;
				s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
			else if (!s_axi_rvalid)
				s_axi_arready <= 1'b1;
		end
	end

endmodule // h2_status_frame_and_pwm_encoder

`default_nettype wire

/* File: testbench/h2_frame_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module h2_frame_sva #(
	parameter REPEAT_CYC = 40,
	parameter PWM_PERIOD_CYC = 3000
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [63:0] status_frame_ff,
	input wire logic frame_valid_ff,
	input wire logic can_dominant_ff
);
	reg seen_ff, fell_ff, dom_ff;
	reg [7:0] cnt_ff;
	reg [31:0] gap_ff, per_ff, rec_ff;
	wire fv = frame_valid_ff;
	wire [63:0] f = status_frame_ff;
	wire fall = dom_ff && !can_dominant_ff;
	wire [9:0] sum = {f[33:32], f[15:8]} + {f[50:49], f[7:0]} + {8'h00, f[41:40]};
	// Low run is only trusted once a period edge has been seen
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			seen_ff <= 1'b0;
			fell_ff <= 1'b0;
			dom_ff <= 1'b0;
			cnt_ff <= 8'h00;
			gap_ff <= 32'h0;
			per_ff <= 32'h0;
			rec_ff <= 32'h0;
		end
		else
		begin
			seen_ff <= seen_ff | fv;
			fell_ff <= fell_ff | fall;
			dom_ff <= can_dominant_ff;
			cnt_ff <= fv ? f[47:40] : cnt_ff;
			gap_ff <= fv ? 32'h1 : gap_ff + 32'h1;
			per_ff <= fall ? 32'h1 : per_ff + 32'h1;
			rec_ff <= can_dominant_ff ? 32'h0 : rec_ff + 32'h1;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	property p_pulse; fv |=> !fv; endproperty
	a_pulse: assert property (p_pulse) else $error("frame strobe too long");
	property p_hold; !fv |-> $stable(status_frame_ff); endproperty
	a_hold: assert property (p_hold) else $error("frame changed without strobe");
	property p_zero; fv |-> !f[48] && !f[37]; endproperty
	a_zero: assert property (p_zero) else $error("spare frame bit set");
	property p_code; fv |-> f[7:0] >= 8'h14 && f[7:0] <= 8'hF0; endproperty
	a_code: assert property (p_code) else $error("code out of range");
	property p_check; fv |-> sum == 10'h000; endproperty
	a_check: assert property (p_check) else $error("check word wrong");
	property p_count; fv && seen_ff |-> f[47:40] == cnt_ff + 8'h01; endproperty
	a_count: assert property (p_count) else $error("counter step wrong");
	property p_gap; fv && seen_ff |-> gap_ff % REPEAT_CYC == 0; endproperty
	a_gap: assert property (p_gap) else $error("frame spacing wrong");
	property p_period; fall && fell_ff |-> per_ff == PWM_PERIOD_CYC; endproperty
	a_period: assert property (p_period) else $error("pulse period wrong");
	property p_width; $rose(can_dominant_ff) && fell_ff |-> rec_ff == 32'h4E2
		|| (rec_ff % 32'h7D == 0 && rec_ff >= 32'h9C4 && rec_ff <= 32'h7530); endproperty
	a_width: assert property (p_width) else $error("recessive width wrong");
endmodule // h2_frame_sva
bind h2_status_frame_and_pwm_encoder h2_frame_sva #(
	.REPEAT_CYC(REPEAT_CYC),
	.PWM_PERIOD_CYC(PWM_PERIOD_CYC)
) i_sva (
	.mclk(mclk),
	.nrst(nrst),
	.status_frame_ff(status_frame_ff),
	.frame_valid_ff(frame_valid_ff),
	.can_dominant_ff(can_dominant_ff)
);
`default_nettype wire

/* File: testbench/pwm_width_receiver.sv */
`timescale 1ns/1ps
`default_nettype none
module pwm_width_receiver (
	input wire logic mclk,
	input wire logic can_dominant_ff,
	input wire logic [63:0] status_frame_ff,
	output logic [15:0] width_us,
	output logic [15:0] ppm
);
	int low_cyc = 0;
	assign ppm = (16'(status_frame_ff[7:0]) - 16'h14) * 16'hC8;
	always @(posedge mclk)
	begin
		if (!can_dominant_ff)
			low_cyc <= low_cyc + 1;
		else
		begin
			if (low_cyc > 0)
				width_us <= 16'(low_cyc / 125);
			low_cyc <= 0;
		end
	end
endmodule // pwm_width_receiver
`default_nettype wire

/* File: testbench/test_h2_status_frame_and_pwm_encoder.sv */
`timescale 1ns/1ps
`default_nettype none
module test_h2_status_frame_and_pwm_encoder;
	localparam int ST = 50;
	localparam int RP = 40;
	localparam int PP = 3000;
	logic mclk = 1'b0, nrst = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, ecnt;
	logic [31:0] s_axi_wdata = '0, rd, raw, part;
	logic [2:0] feed = 3'h5;
	logic [1:0] rsp;
	logic [63:0] f;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire frame_valid_ff, can_dominant_ff;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [63:0] status_frame_ff;
	wire [10:0] can_id_ff;
	wire [15:0] w_us, ppm;
	int n_errors = 0, check_count = 0, n_fr = 0, t_first = 0, cyc = 0;
	int pp[5] = '{0, 299, 300, 44000, 50000};
	logic [7:0] cd[5] = '{8'h14, 8'h15, 8'h16, 8'hF0, 8'hF0};
	h2_status_frame_and_pwm_encoder #(.START_CYC(ST), .REPEAT_CYC(RP), .PWM_PERIOD_CYC(PP)) i_dut (
		.mclk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .id_feed_bit0(feed[0]),
		.id_feed_bit1(feed[1]), .id_feed_bit2(feed[2]), .status_frame_ff, .frame_valid_ff,
		.can_id_ff, .can_dominant_ff);
	pwm_width_receiver i_rx (.mclk, .can_dominant_ff, .status_frame_ff, .width_us(w_us), .ppm);
	initial
	begin
		forever #4 mclk = ~mclk;
	end
	always @(posedge mclk)
	begin
		cyc <= nrst ? cyc + 1 : 0;
		if (frame_valid_ff === 1'b1) n_fr <= n_fr + 1;
		if (frame_valid_ff === 1'b1 && n_fr == 0) t_first <= cyc;
	end
	task print_verdict;
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		check_count++;
		if (s !== e)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	// Holds each channel until its own ready, then waits for the answer
	task axi(input logic we, input logic [7:0] a, input logic [31:0] d);
		int i;
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= we;
		s_axi_wvalid <= we;
		s_axi_bready <= we;
		s_axi_arvalid <= !we;
		s_axi_rready <= !we;
		for (i = 0; i < 50 && (i == 0 || s_axi_bready || s_axi_rready); i++)
		begin
			@(posedge mclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_bvalid && s_axi_bready) rsp = s_axi_bresp;
			if (s_axi_bvalid && s_axi_bready) s_axi_bready <= 1'b0;
			if (s_axi_rvalid && s_axi_rready) rsp = s_axi_rresp;
			if (s_axi_rvalid && s_axi_rready) rd = s_axi_rdata;
			if (s_axi_rvalid && s_axi_rready) s_axi_rready <= 1'b0;
		end
		if (i == 50) n_errors++;
		if (i == 50) print_verdict;
	endtask
	function automatic logic [15:0] crc(input logic [63:0] x);
		logic [15:0] c = 16'hFFFF;
		for (int k = 0; k < 7; k++)
			for (int j = 7; j >= 0 && k != 3; j--)
				c = {c[14:0], 1'b0} ^ ((c[15] ^ x[8 * k + j]) ? 16'h1021 : 16'h0000);
		return c;
	endfunction
	task cfr(input logic [7:0] code, input logic [1:0] h);
		logic [9:0] pv;
		int i;
		@(negedge mclk);
		for (i = 0; i < 200 && frame_valid_ff !== 1'b1; i++)
			@(negedge mclk);
		if (i == 200) n_errors++;
		if (i == 200) print_verdict;
		f = status_frame_ff;
		ecnt = 8'(n_fr + 1);
		pv = ~({h, code} + {8'h00, ecnt[1:0]}) + 10'h001;
		chk("code", code, f[7:0]);
		chk("ppm", (code - 20) * 200, ppm);
		chk("check", pv, {f[33:32], f[15:8]});
		chk("raw", raw[9:0], {f[23:16], f[39:38]});
		chk("crc", crc(f), {f[31:24], f[63:56]});
		chk("sensor", 32'h5, f[36:34]);
		chk("count", ecnt, f[47:40]);
		chk("health", h, f[50:49]);
		chk("part", part, f[55:51]);
		@(posedge mclk);
	endtask
	task test_reset;
		chk("dom_off", 32'h0, can_dominant_ff);
		axi(1'b0, 8'h1C, 32'h0);
		chk("info_cnt", 32'h1, rd[7:0]);
		chk("can_id", 32'h660, can_id_ff);
		axi(1'b0, 8'h10, 32'h0);
		chk("part_rst", 32'h1, rd);
		axi(1'b0, 8'h20, 32'h0);
		chk("bad_rsp", 32'h2, {rd[1:0], rsp});
		axi(1'b1, 8'h14, 32'hFF);
		chk("ro_rsp", 32'h2, rsp);
		$display("test_reset done");
	endtask
	task test_frames;
		raw = 32'h0;
		part = 32'h1;
		cfr(8'h14, 2'h0);
		for (int i = 0; i < 5; i++)
		begin
			raw = i * 200 + 3;
			part = i + 2;
			axi(1'b1, 8'h04, pp[i]);
			axi(1'b1, 8'h08, i % 4);
			axi(1'b1, 8'h0C, raw);
			axi(1'b1, 8'h10, part);
			cfr(cd[i], 2'(i % 4));
		end
		chk("first", 32'h1, t_first >= ST && t_first <= ST + 1);
		$display("test_frames done");
	endtask
	task test_wrap;
		int n;
		while (n_fr < 258)
			cfr(8'hF0, 2'h0);
		axi(1'b0, 8'h14, 32'h0);
		chk("frame_lo", f[31:0], rd);
		axi(1'b0, 8'h18, 32'h0);
		chk("frame_hi", f[63:32], rd);
		axi(1'b0, 8'h1C, 32'h0);
		chk("info", {16'h8660, 8'h05, ecnt + 8'h01}, rd);
		axi(1'b1, 8'h00, 32'h0);
		n = n_fr;
		repeat (3 * RP) @(posedge mclk);
		chk("tx_off", n, n_fr);
		$display("test_wrap done");
	endtask
	task test_pwm;
		int n;
		axi(1'b1, 8'h04, 32'h12C);
		axi(1'b1, 8'h00, 32'h3);
		repeat (PP) @(posedge mclk);
		n = n_fr;
		repeat (2 * PP) @(posedge mclk);
		chk("no_frames", n, n_fr);
		chk("width", 32'h16, w_us);
		axi(1'b1, 8'h08, 32'h3);
		repeat (3 * PP) @(posedge mclk);
		chk("err_width", 32'hA, w_us);
		$display("test_pwm done");
	endtask
	initial
	begin
		repeat (2) @(posedge mclk);
		nrst <= 1'b1;
		@(posedge mclk);
		test_reset;
		test_frames;
		test_wrap;
		test_pwm;
		print_verdict;
	end
endmodule // test_h2_status_frame_and_pwm_encoder
`default_nettype wire
